// file: hw/i2csp_consts.vh
// Constants for the two-wire serial slave register port
// Functional notes
// - Start: data falls while clock high
// - First byte: seven address bits, direction bit
// - Selected only when received address matches own
// - Ninth clock: receiver pulls data low
// - Repeated start turns pointer write into read
// - Stop: data rises while clock high, ends
// - Own address 0011101, bytes 0x3B/0x3A
// - Works at 100 kHz and 400 kHz
// - Bytes shifted most significant bit first
// - Read: acknowledge address byte and index byte
// - After repeated start, return selected register
// - Burst read advances pointer after each ACK
// - Write: acknowledge address, index, data bytes (a data byte is refused while the write queue is full)
// - Store byte at pointer, then advance pointer
// - Idle bus: slave drives neither line
// - Drive data line only when addressed
// - Buffered mode read burst from 0x01 wraps
`ifndef I2CSP_CONSTS_VH
`define I2CSP_CONSTS_VH

// Bus address and direction
`define I2CSP_DEV_ADDR     7'h1D
`define I2CSP_RD_BYTE      8'h3B
`define I2CSP_WR_BYTE      8'h3A
`define I2CSP_DIR_READ     1'b1

// Byte framing
`define I2CSP_BYTE_BITS    4'h8
`define I2CSP_LAST_TX_BIT  4'h7
`define I2CSP_MSB          7

// Register pointer
`define I2CSP_PTR_RESET    8'h00
`define I2CSP_PTR_STEP     8'h01
`define I2CSP_ROOT_PTR     8'h01
`define I2CSP_ROOT_LAST    8'h06

// Timing: system clock and data hold after the clock's falling edge
`define I2CSP_CLK_MHZ      10
`define I2CSP_NS_PER_US    1000
`define I2CSP_STD_KHZ      100
`define I2CSP_FAST_KHZ     400
`define I2CSP_HOLD_NS      300
`define I2CSP_HOLD_CYC     (((`I2CSP_HOLD_NS * `I2CSP_CLK_MHZ) + `I2CSP_NS_PER_US - 1) / `I2CSP_NS_PER_US)
`define I2CSP_FAST_LOW_NS  1300
`define I2CSP_FAST_LOW_CYC ((`I2CSP_FAST_LOW_NS * `I2CSP_CLK_MHZ) / `I2CSP_NS_PER_US)

// Write queue
`define I2CSP_FIFO_DEPTH   16
`define I2CSP_FIFO_AW      4

`endif

// file: hw/i2csp_sync.v
// Two-flop synchroniser for the bus pins
`timescale 1ns/100ps
module i2csp_sync #(
   parameter WIDTH = 2
) (
   input  wire             i_clk,
   input  wire             i_srst,
   input  wire [WIDTH-1:0] i_async,
   output reg  [WIDTH-1:0] o_sync
);

   reg [WIDTH-1:0] meta;

   // Reset to released lines so no false edge appears after reset
   always @(posedge i_clk) begin
      if (i_srst) begin
         meta   <= {WIDTH{1'b1}};
         o_sync <= {WIDTH{1'b1}};
      end else begin
         meta   <= i_async;
         o_sync <= meta;
      end
   end

endmodule

// file: hw/i2csp_fifo.v
// Flop-based FIFO with a registered output stage
`timescale 1ns/100ps
module i2csp_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             i_clk,
   input  wire             i_srst,
   input  wire             i_in_valid,
   output wire             o_in_ready,
   input  wire [WIDTH-1:0] i_in_data,
   output reg              o_out_valid,
   input  wire             i_out_ready,
   output reg  [WIDTH-1:0] o_out_data
);

   localparam integer FULL_I = DEPTH;
   localparam [AW:0]  FULL   = FULL_I[AW:0];

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wp;
   reg [AW-1:0]    rp;
   reg [AW:0]      cnt;

   // Pointers wrap naturally, so DEPTH must be a power of two
   wire push = i_in_valid && o_in_ready;
   wire pop  = (cnt != {(AW+1){1'b0}}) && (!o_out_valid || i_out_ready);

   assign o_in_ready = (cnt != FULL);

   // Storage write, output stage refill and occupancy count
   always @(posedge i_clk) begin
      if (i_srst) begin
         wp          <= {AW{1'b0}};
         rp          <= {AW{1'b0}};
         cnt         <= {(AW+1){1'b0}};
         o_out_valid <= 1'b0;
         o_out_data  <= {WIDTH{1'b0}};
      end else begin
         if (push) begin
            mem[wp] <= i_in_data;
            wp      <= wp + 1'b1;
         end
         if (pop) begin
            o_out_data <= mem[rp];
            rp         <= rp + 1'b1;
         end
         if (pop)
            o_out_valid <= 1'b1;
         else if (i_out_ready)
            o_out_valid <= 1'b0;
         case ({push, pop})
            2'b10:   cnt <= cnt + 1'b1;
            2'b01:   cnt <= cnt - 1'b1;
            default: cnt <= cnt;
         endcase
      end
   end

endmodule

// file: hw/i2csp_top.v
// Two-wire serial slave giving a bus master access to a byte register space
`timescale 1ns/100ps
`include "i2csp_consts.vh"
module i2csp_top #(
   parameter FIFO_DEPTH = `I2CSP_FIFO_DEPTH,
   parameter FIFO_AW    = `I2CSP_FIFO_AW
) (
   input  wire       I_CLK_SYS,
   input  wire       I_SRST,
   input  wire       i_SCL,
   input  wire       i_SDA,
   output reg        o_SDA_OUT,
   output reg        o_SDA_OE,
   output reg  [7:0] o_RD_ADDR,
   input  wire [7:0] i_RD_DATA,
   output wire       o_WR_VALID,
   input  wire       i_WR_READY,
   output wire [7:0] o_WR_ADDR,
   output wire [7:0] o_WR_DATA,
   input  wire       i_FIFO_MODE,
   output reg        o_BUSY,
   output reg        o_SELECTED
);

   // Protocol states
   localparam [2:0] ST_IDLE    = 3'h0;
   localparam [2:0] ST_ADDR    = 3'h1;
   localparam [2:0] ST_ACK_AD  = 3'h2;
   localparam [2:0] ST_RX      = 3'h3;
   localparam [2:0] ST_ACK_RX  = 3'h4;
   localparam [2:0] ST_TX      = 3'h5;
   localparam [2:0] ST_ACK_TX  = 3'h6;
   localparam [2:0] ST_IGNORE  = 3'h7;

   // Hold delay keeps data stable past the clock fall at either bus rate
   localparam integer HOLD_CYC_I = `I2CSP_HOLD_CYC;
   localparam [3:0]   HOLD_CYC   = HOLD_CYC_I[3:0];

   reg  [2:0]  state;
   reg  [3:0]  bitcnt;
   reg  [7:0]  shreg;
   reg         dir_read;
   reg         index_phase;
   reg         root_burst;
   reg         master_ack;
   reg         drv_pend;
   reg  [3:0]  hold_cnt;
   reg         scl_q;
   reg         sda_q;
   reg         wr_push;
   reg  [15:0] wr_word;
   wire [1:0]  pins_sync;
   wire        scl_s;
   wire        sda_s;
   wire        fifo_ready;
   wire [15:0] fifo_out;

   // Pointer advance; in buffered mode a read burst from the root wraps
   function [7:0] ptr_next;
      input [7:0] ptr;
      input       wrap;
      begin
         if (wrap && (ptr == `I2CSP_ROOT_LAST))
            ptr_next = `I2CSP_ROOT_PTR;
         else
            ptr_next = ptr + `I2CSP_PTR_STEP;
      end
   endfunction

   // Both pins come from outside this clock domain
   i2csp_sync #(
      .WIDTH   (2)
   ) u_sync (
      .i_clk   (I_CLK_SYS),
      .i_srst  (I_SRST),
      .i_async ({i_SCL, i_SDA}),
      .o_sync  (pins_sync)
   );

   assign scl_s = pins_sync[1];
   assign sda_s = pins_sync[0];

   // Previous sampled levels for edge and condition detection
   always @(posedge I_CLK_SYS) begin
      if (I_SRST) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
      end
   end

   wire scl_rise = scl_s & ~scl_q;
   wire scl_fall = ~scl_s & scl_q;
   wire bus_start = scl_s & scl_q & sda_q & ~sda_s;
   wire bus_stop  = scl_s & scl_q & ~sda_q & sda_s;

   // Written bytes queue up as {pointer, data} for the register file
   i2csp_fifo #(
      .WIDTH       (16),
      .DEPTH       (FIFO_DEPTH),
      .AW          (FIFO_AW)
   ) u_fifo (
      .i_clk       (I_CLK_SYS),
      .i_srst      (I_SRST),
      .i_in_valid  (wr_push),
      .o_in_ready  (fifo_ready),
      .i_in_data   (wr_word),
      .o_out_valid (o_WR_VALID),
      .i_out_ready (i_WR_READY),
      .o_out_data  (fifo_out)
   );

   assign o_WR_ADDR = fifo_out[15:8];
   assign o_WR_DATA = fifo_out[7:0];

   // Protocol engine; drive changes at clock falls are queued in drv_pend and
   // applied after the hold delay so the master sees clean hold time
   always @(posedge I_CLK_SYS) begin
      if (I_SRST) begin
         state       <= ST_IDLE;
         bitcnt      <= 4'h0;
         shreg       <= 8'h00;
         dir_read    <= 1'b0;
         index_phase <= 1'b0;
         root_burst  <= 1'b0;
         master_ack  <= 1'b0;
         drv_pend    <= 1'b0;
         hold_cnt    <= 4'h0;
         o_SDA_OUT   <= 1'b0;
         o_SDA_OE    <= 1'b0;
         o_RD_ADDR   <= `I2CSP_PTR_RESET;
         o_BUSY      <= 1'b0;
         o_SELECTED  <= 1'b0;
         wr_push     <= 1'b0;
         wr_word     <= 16'h0000;
      end else begin
         wr_push   <= 1'b0;
         o_SDA_OUT <= 1'b0;
         // Delayed pin update, one output-enable level update per queued change
         if (hold_cnt != 4'h0) begin
            hold_cnt <= hold_cnt - 4'h1;
            if (hold_cnt == 4'h1)
               o_SDA_OE <= drv_pend;
         end
         if (bus_stop) begin
            // End of transaction; bus idle, lines released
            state      <= ST_IDLE;
            o_BUSY     <= 1'b0;
            o_SELECTED <= 1'b0;
            o_SDA_OE   <= 1'b0;
            drv_pend   <= 1'b0;
            hold_cnt   <= 4'h0;
         end else if (bus_start) begin
            // First or repeated start; pointer is kept across a repeat
            state      <= ST_ADDR;
            o_BUSY     <= 1'b1;
            o_SELECTED <= 1'b0;
            bitcnt     <= 4'h0;
            o_SDA_OE   <= 1'b0;
            drv_pend   <= 1'b0;
            hold_cnt   <= 4'h0;
         end else begin
            case (state)
               ST_IDLE: begin
                  drv_pend <= 1'b0;
               end
               ST_ADDR, ST_RX: begin
                  if (scl_rise && (bitcnt != `I2CSP_BYTE_BITS)) begin
                     shreg  <= {shreg[6:0], sda_s};
                     bitcnt <= bitcnt + 4'h1;
                  end else if (scl_fall && (bitcnt == `I2CSP_BYTE_BITS)) begin
                     bitcnt   <= 4'h0;
                     hold_cnt <= HOLD_CYC;
                     if (state == ST_ADDR) begin
                        if (shreg[7:1] == `I2CSP_DEV_ADDR) begin
                           dir_read    <= shreg[0];
                           o_SELECTED  <= 1'b1;
                           index_phase <= 1'b1;
                           drv_pend    <= 1'b1;
                           state       <= ST_ACK_AD;
                        end else begin
                           drv_pend <= 1'b0;
                           state    <= ST_IGNORE;
                        end
                     end else if (index_phase) begin
                        // Index byte loads the pointer
                        index_phase <= 1'b0;
                        o_RD_ADDR   <= shreg;
                        drv_pend    <= 1'b1;
                        state       <= ST_ACK_RX;
                     end else if (fifo_ready) begin
                        // Data byte stored at the pointer, then advance
                        wr_push   <= 1'b1;
                        wr_word   <= {o_RD_ADDR, shreg};
                        o_RD_ADDR <= ptr_next(o_RD_ADDR, 1'b0);
                        drv_pend  <= 1'b1;
                        state     <= ST_ACK_RX;
                     end else begin
                        // Queue full: refuse the byte so the master knows
                        drv_pend <= 1'b0;
                        state    <= ST_IGNORE;
                     end
                  end
               end
               ST_ACK_AD: begin
                  // Release after the acknowledge clock, or start sending
                  if (scl_fall) begin
                     hold_cnt <= HOLD_CYC;
                     if (dir_read == `I2CSP_DIR_READ) begin
                        shreg      <= i_RD_DATA;
                        drv_pend   <= ~i_RD_DATA[`I2CSP_MSB];
                        root_burst <= i_FIFO_MODE && (o_RD_ADDR == `I2CSP_ROOT_PTR);
                        bitcnt     <= 4'h0;
                        state      <= ST_TX;
                     end else begin
                        drv_pend <= 1'b0;
                        state    <= ST_RX;
                     end
                  end
               end
               ST_ACK_RX: begin
                  if (scl_fall) begin
                     hold_cnt <= HOLD_CYC;
                     drv_pend <= 1'b0;
                     state    <= ST_RX;
                  end
               end
               ST_TX: begin
                  // Shift out on each falling clock edge
                  if (scl_fall) begin
                     hold_cnt <= HOLD_CYC;
                     if (bitcnt == `I2CSP_LAST_TX_BIT) begin
                        drv_pend <= 1'b0;
                        state    <= ST_ACK_TX;
                     end else begin
                        bitcnt   <= bitcnt + 4'h1;
                        shreg    <= {shreg[6:0], 1'b0};
                        drv_pend <= ~shreg[`I2CSP_MSB-1];
                     end
                  end
               end
               ST_ACK_TX: begin
                  // Master acknowledge sampled in the clock's high phase
                  if (scl_rise) begin
                     master_ack <= ~sda_s;
                     if (~sda_s)
                        o_RD_ADDR <= ptr_next(o_RD_ADDR, root_burst);
                  end else if (scl_fall) begin
                     hold_cnt <= HOLD_CYC;
                     bitcnt   <= 4'h0;
                     if (master_ack) begin
                        shreg    <= i_RD_DATA;
                        drv_pend <= ~i_RD_DATA[`I2CSP_MSB];
                        state    <= ST_TX;
                     end else begin
                        // No acknowledge: wait for the stop
                        drv_pend <= 1'b0;
                        state    <= ST_IGNORE;
                     end
                  end
               end
               ST_IGNORE: begin
                  // Bus stays untouched until the next start or stop
                  drv_pend <= 1'b0;
               end
               default: begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end

endmodule

// file: tb/i2csp_master_model.sv
// Bus master model for the serial slave port
`timescale 1ns/100ps
module i2csp_master_model #(
   parameter T_LO = 7,
   parameter T_HI = 1,
   parameter T_SU = 4
) (
   input  wire i_clk,
   input  wire i_sda,
   output reg  o_scl,
   output reg  o_sda
);
   // Idle lines rest high; the low phase outlasts the slave's hold delay
   initial begin
      o_scl = 1'h1;
      o_sda = 1'h1;
   end
   task tick(input integer n);
      repeat (n) @(negedge i_clk);
   endtask
   // One clock pulse: data set late in low phase, sampled late in high phase
   task pulse(input v, output s);
      tick(T_LO - 1);
      o_sda = v;
      tick(1);
      o_scl = 1'h1;
      tick(T_HI - 1);
      s = i_sda;
      tick(1);
      o_scl = 1'h0;
   endtask
   // Start and stop get a longer high phase so the synchronised pins settle
   task start;
      tick(T_LO - 1);
      o_sda = 1'h1;
      tick(1);
      o_scl = 1'h1;
      tick(T_SU);
      o_sda = 1'h0;
      tick(T_SU);
      o_scl = 1'h0;
   endtask
   task stop;
      tick(T_LO - 1);
      o_sda = 1'h0;
      tick(1);
      o_scl = 1'h1;
      tick(T_SU);
      o_sda = 1'h1;
      tick(T_SU);
   endtask
   // Byte out, then line released for the slave's acknowledge
   task wr_byte(input [7:0] b, output ack);
      reg     s;
      integer i;
      for (i = 7; i >= 0; i = i - 1) pulse(b[i], s);
      pulse(1'h1, s);
      ack = ~s;
   endtask
   task rd_byte(input ack, output [7:0] b);
      reg     s;
      integer i;
      for (i = 7; i >= 0; i = i - 1) begin
         pulse(1'h1, s);
         b[i] = s;
      end
      pulse(~ack, s);
   endtask
endmodule

// file: tb/i2csp_monitor.sv
// Checker for bus and write-queue behaviour of the slave port
`timescale 1ns/100ps
module i2csp_monitor (
   input wire       I_CLK_SYS,
   input wire       I_SRST,
   input wire       i_SCL,
   input wire       i_SDA,
   input wire       o_SDA_OE,
   input wire       o_WR_VALID,
   input wire       i_WR_READY,
   input wire [7:0] o_WR_ADDR,
   input wire [7:0] o_WR_DATA,
   input wire       o_BUSY,
   input wire       o_SELECTED
);
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (I_SRST);
   // One cycle of slack lets the stop hand-off settle
   idle_no_drive_a: assert property (!o_BUSY && !$past(o_BUSY) |-> !o_SDA_OE)
      else $error("slave drives an idle bus");
   start_busy_a: assert property ($fell(i_SDA) && i_SCL |-> ##[1:6] o_BUSY)
      else $error("start not flagged busy");
   stop_idle_a: assert property ($rose(i_SDA) && i_SCL |->
      ##[1:6] (!o_BUSY && !o_SELECTED && !o_SDA_OE))
      else $error("stop did not end transaction");
   sel_clear_a: assert property ($fell(i_SDA) && i_SCL |-> ##[1:6] !o_SELECTED)
      else $error("selection kept over start");
   oe_needs_sel_a: assert property ($rose(o_SDA_OE) |-> o_SELECTED)
      else $error("drive while not addressed");
   oe_rise_low_a: assert property ($rose(o_SDA_OE) |-> !i_SCL)
      else $error("data driven with clock high");
   ack_hold_a: assert property (o_SDA_OE && $rose(i_SCL) |-> o_SDA_OE [*3])
      else $error("low not held through high phase");
   wr_hold_a: assert property (o_WR_VALID && !i_WR_READY |=>
      o_WR_VALID && $stable(o_WR_ADDR) && $stable(o_WR_DATA))
      else $error("write word changed while stalled");
endmodule
bind i2csp_top i2csp_monitor mon_u (.I_CLK_SYS(I_CLK_SYS), .I_SRST(I_SRST), .i_SCL(i_SCL),
   .i_SDA(i_SDA), .o_SDA_OE(o_SDA_OE), .o_WR_VALID(o_WR_VALID), .i_WR_READY(i_WR_READY),
   .o_WR_ADDR(o_WR_ADDR), .o_WR_DATA(o_WR_DATA), .o_BUSY(o_BUSY), .o_SELECTED(o_SELECTED));

// file: tb/tb_i2c_slave_register_port.sv
// Self-checking bench for the serial slave register port
`timescale 1ns/100ps
module tb_i2c_slave_register_port;
   localparam KEY = 8'h5C;
   reg        clk;
   reg        rst;
   reg        wr_ready;
   reg        fifo_mode;
   wire       scl;
   wire       m_sda;
   wire       sda;
   wire       sda_out;
   wire       sda_oe;
   wire [7:0] rd_addr;
   wire [7:0] rd_data;
   wire       wr_valid;
   wire [7:0] wr_addr;
   wire [7:0] wr_data;
   wire       busy;
   wire       sel;
   integer    fails;
   integer    cmp_count;
   integer    i;
   reg        a;
   reg [7:0]  d;
   reg [15:0] wq[$];
   // Pull-up wire: low when either party pulls; register file stand-in
   assign sda = m_sda & (sda_oe ? sda_out : 1'h1);
   assign rd_data = rd_addr ^ KEY;
   initial begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end
   i2csp_top dut_u (.I_CLK_SYS(clk), .I_SRST(rst), .i_SCL(scl), .i_SDA(sda),
      .o_SDA_OUT(sda_out), .o_SDA_OE(sda_oe), .o_RD_ADDR(rd_addr), .i_RD_DATA(rd_data),
      .o_WR_VALID(wr_valid), .i_WR_READY(wr_ready), .o_WR_ADDR(wr_addr),
      .o_WR_DATA(wr_data), .i_FIFO_MODE(fifo_mode), .o_BUSY(busy), .o_SELECTED(sel));
   i2csp_master_model bm (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(m_sda));
   // Log each word the register file takes
   always @(posedge clk) begin
      if (!rst && wr_valid === 1'h1 && wr_ready === 1'h1) wq.push_back({wr_addr, wr_data});
   end
   task chk(input string name, input [15:0] exp, input [15:0] got);
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
         fails = fails + 1;
         $display("BAD %0s exp %h got %h", name, exp, got);
      end
   endtask
   task wb(input [7:0] b, input ea);
      bm.wr_byte(b, a);
      chk("ack", ea, a);
   endtask
   task rb(input ack, input [7:0] e);
      bm.rd_byte(ack, d);
      chk("rdata", e, d);
   endtask
   task t_write;
      wq.delete();
      bm.start();
      wb(8'h3A, 1'h1);
      chk("sel", 1'h1, sel);
      wb(8'h10, 1'h1);
      wb(8'hA5, 1'h1);
      wb(8'h5A, 1'h1);
      bm.stop();
      repeat (8) @(negedge clk);
      chk("busy", 1'h0, busy);
      chk("words", 16'h0002, wq.size());
      chk("w0", 16'h10A5, wq[0]);
      chk("w1", 16'h115A, wq[1]);
      $display("test write done");
   endtask
   task t_read;
      bm.start();
      wb(8'h3A, 1'h1);
      wb(8'h20, 1'h1);
      bm.start();
      wb(8'h3B, 1'h1);
      rb(1'h1, 8'h20 ^ KEY);
      rb(1'h0, 8'h21 ^ KEY);
      bm.stop();
      chk("ptr", 8'h21, rd_addr);
      $display("test read done");
   endtask
   task t_other;
      bm.start();
      wb(8'h50, 1'h0);
      chk("sel", 1'h0, sel);
      wb(8'h3A, 1'h0);
      bm.stop();
      $display("test foreign address done");
   endtask
   task t_fifo;
      @(negedge clk);
      fifo_mode = 1'h1;
      bm.start();
      wb(8'h3A, 1'h1);
      wb(8'h01, 1'h1);
      bm.start();
      wb(8'h3B, 1'h1);
      for (i = 0; i < 7; i = i + 1) rb(i < 6, ((i % 6) + 1) ^ KEY);
      bm.stop();
      fifo_mode = 1'h0;
      $display("test buffered mode done");
   endtask
   // Queue full: 16 entries plus the output stage, the next byte refused
   task t_full;
      wq.delete();
      @(negedge clk);
      wr_ready = 1'h0;
      bm.start();
      wb(8'h3A, 1'h1);
      wb(8'h40, 1'h1);
      for (i = 0; i < 18; i = i + 1) wb(i, i < 17);
      bm.stop();
      wr_ready = 1'h1;
      repeat (40) @(negedge clk);
      chk("words", 16'h0011, wq.size());
      chk("w0", 16'h4000, wq[0]);
      chk("w16", 16'h5010, wq[16]);
      chk("wvalid", 1'h0, wr_valid);
      $display("test full queue done");
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Watchdog: all tests need well under 10000 cycles
   initial begin
      repeat (30000) @(posedge clk);
      fails = fails + 1;
      $display("BAD watchdog exp done got hang");
      report_and_stop;
   end
   // Main sequence
   initial begin
      fails = 0;
      cmp_count = 0;
      rst = 1'h1;
      wr_ready = 1'h1;
      fifo_mode = 1'h0;
      repeat (16) @(negedge clk);
      rst = 1'h0;
      repeat (4) @(negedge clk);
      chk("oe", 1'h0, sda_oe);
      chk("busy", 1'h0, busy);
      chk("ptr", 8'h00, rd_addr);
      chk("wvalid", 1'h0, wr_valid);
      t_write;
      t_read;
      t_other;
      t_fifo;
      t_full;
      report_and_stop;
   end
endmodule
